// ---- frac_accum.sv ----
`timescale 1ns/1ps
// per frame: integer part of rate plus carried fraction goes out, fraction stays
module frac_accum #(
    parameter int IW = 16,
    parameter int FW = 16
) (
    input  wire logic            clk_i,
    input  wire logic            resetn_i,
    input  wire logic            run_i,
    input  wire logic            frame_i,
    input  wire logic [IW+FW-1:0] rate_i,
    output logic      [IW-1:0]   count_o,
    output logic                 strobe_o
);
    logic [FW-1:0]  frac_q;
    logic [IW+FW:0] sum;

    assign sum = {{(IW+1){1'b0}}, frac_q} + {1'b0, rate_i};

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            frac_q   <= '0;
            count_o  <= '0;
            strobe_o <= 1'b0;
        end else begin
            strobe_o <= run_i && frame_i;
            if (!run_i) begin
                frac_q <= '0;
            end else if (frame_i) begin
                count_o <= sum[IW+FW-1:FW];
                frac_q  <= sum[FW-1:0];
            end
        end
    end
endmodule // frac_accum

// ---- host_model.sv ----
`timescale 1ns/1ps
// ****************************************
// frame ticks and master clock, seen from the host side
// ****************************************
module host_model #(
    parameter int FRAME = 200
) (
    input  wire logic clk_i,
    output logic      sof_o,
    output logic      mclk_o
);
    int frame_q = 0;
    int div_q   = 0;
    // sof stands 4 cycles so the two-stage synchroniser cannot miss it
    always_ff @(posedge clk_i) begin
        frame_q <= (frame_q == FRAME - 1) ? 0 : frame_q + 1;
        div_q   <= div_q + 1;
    end
    assign sof_o  = (frame_q < 4);
    // master clock at a quarter of the system clock, two cycles high
    assign mclk_o = div_q[1];
endmodule // host_model

// ---- iso_rate_feedback.sv ----
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module iso_rate_feedback #(
    parameter int CW = 25,
    parameter int EW = 4
) (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic [5:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    input  wire logic [3:0]  byteenable_i,
    output logic      [31:0] readdata_o,
    output logic             waitrequest_o,
    input  wire logic        sof_i,
    input  wire logic        master_clk_i,
    input  wire logic        rx_sample_i,
    input  wire logic        tx_sample_i,
    output logic      [31:0] fb_value_o,
    output logic             fb_new_o,
    output logic      [15:0] src_samples_o,
    output logic             src_samples_vld_o,
    output logic             sample_en_o,
    output logic      [CW-1:0] sink_rate_o
);
    // ****************************************
    // checks and declarations
    // ****************************************
    if (CW < 25 || CW > 32 || EW != 4) begin : g_bad
        $error("iso_rate_feedback: count must hold 12.13, exponent four bits");
    end

    logic                 sof_s1_q, sof_s2_q, sof_s3_q;
    logic                 mck_s1_q, mck_s2_q, mck_s3_q;
    logic                 sof_tick, mck_tick;
    logic                 enable_q, hs_q, implicit_q;
    logic [3:0]           p_q, avg_q;
    iso_rate_pkg::mode_t  mode_q;
    logic [31:0]          host_rate_q;
    logic [7:0]           corr_q;
    logic [15:0]          sync_per_q, sync_div_q;
    logic [11:0]          sync_num_q, sync_cnt_q;
    logic                 chg_q, wait_q;
    logic [3:0]           k, p_eff, fb_exp;
    logic                 fb_run, sink_run, src_run, fb_tick;
    logic [CW-1:0]        fb_cnt, sink_cnt, adj;
    logic                 fb_vld, sink_vld;
    logic [31:0]          fb_enc, src_rate, wr_merged, rd_mux;
    logic                 req, wr_ev, corr_upd_q;

    // ****************************************
    // pin synchronisers
    // ****************************************
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sof_s1_q <= 1'b0;
            sof_s2_q <= 1'b0;
            sof_s3_q <= 1'b0;
            mck_s1_q <= 1'b0;
            mck_s2_q <= 1'b0;
            mck_s3_q <= 1'b0;
        end else begin
            sof_s1_q <= sof_i;
            sof_s2_q <= sof_s1_q;
            sof_s3_q <= sof_s2_q;
            mck_s1_q <= master_clk_i;
            mck_s2_q <= mck_s1_q;
            mck_s3_q <= mck_s2_q;
        end
    end

    assign sof_tick = sof_s2_q && !sof_s3_q;
    assign mck_tick = mck_s2_q && !mck_s3_q;

    // ****************************************
    // exponents
    // ****************************************
    assign k      = hs_q ? iso_rate_pkg::K_HS : iso_rate_pkg::K_FS;
    assign p_eff  = (p_q > k) ? k : p_q;
    // implicit mode counts source samples over 2**K frames, same format
    assign fb_exp = implicit_q ? k : k - p_eff;

    // ****************************************
    // avalon slave
    // ****************************************
    assign req   = (read_i || write_i) && wait_q;
    // a write lands only at the edge where waitrequest is seen low
    assign wr_ev = write_i && !wait_q;

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    assign wr_merged = be_merge(rd_mux, writedata_i, byteenable_i);

    // one wait cycle, then the access completes
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wait_q     <= 1'b1;
            readdata_o <= 32'h0;
        end else begin
            wait_q <= !req;
            if (req && read_i) begin
                readdata_o <= rd_mux;
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0;
        unique case (address_i)
            iso_rate_pkg::OFF_CTRL: begin
                rd_mux[iso_rate_pkg::CTRL_EN]                        = enable_q;
                rd_mux[iso_rate_pkg::CTRL_HS]                        = hs_q;
                rd_mux[iso_rate_pkg::CTRL_P_LO +: 4]                 = p_q;
                rd_mux[iso_rate_pkg::CTRL_MODE +: 2]                 = mode_q;
                rd_mux[iso_rate_pkg::CTRL_IMPL]                      = implicit_q;
                rd_mux[iso_rate_pkg::CTRL_AVG +: 4]                  = avg_q;
            end
            iso_rate_pkg::OFF_STATUS: begin
                rd_mux[iso_rate_pkg::ST_PWARN] = (p_eff == 4'h0) || (p_eff == k);
                rd_mux[iso_rate_pkg::ST_FBVLD] = fb_run;
                rd_mux[iso_rate_pkg::ST_CHG]   = chg_q;
                rd_mux[iso_rate_pkg::ST_CLAMP] = (p_q > k);
            end
            iso_rate_pkg::OFF_FEEDBACK:  rd_mux = fb_value_o;
            iso_rate_pkg::OFF_HOST_RATE: rd_mux = host_rate_q;
            iso_rate_pkg::OFF_CORR:      rd_mux = {24'h0, corr_q};
            iso_rate_pkg::OFF_SYNC_PER:  rd_mux = {16'h0, sync_per_q};
            iso_rate_pkg::OFF_SYNC_NUM:  rd_mux = {20'h0, sync_num_q};
            iso_rate_pkg::OFF_SINK_RATE: rd_mux = {{(32-CW){1'b0}}, sink_rate_o};
            iso_rate_pkg::OFF_SRC_COUNT: rd_mux = {16'h0, src_samples_o};
            default:                     rd_mux = 32'h0;
        endcase
    end

    // ****************************************
    // control registers
    // ****************************************
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            enable_q   <= 1'b0;
            hs_q       <= 1'b0;
            p_q        <= iso_rate_pkg::P_RST;
            mode_q     <= iso_rate_pkg::MODE_ASYNC;
            implicit_q <= 1'b0;
            avg_q      <= iso_rate_pkg::AVG_RST;
        end else if (wr_ev && address_i == iso_rate_pkg::OFF_CTRL) begin
            enable_q <= wr_merged[iso_rate_pkg::CTRL_EN];
            // rate setup is fixed once streaming starts
            if (!enable_q) begin
                hs_q       <= wr_merged[iso_rate_pkg::CTRL_HS];
                p_q        <= wr_merged[iso_rate_pkg::CTRL_P_LO +: 4];
                mode_q     <= iso_rate_pkg::mode_t'(wr_merged[iso_rate_pkg::CTRL_MODE +: 2]);
                implicit_q <= wr_merged[iso_rate_pkg::CTRL_IMPL];
                avg_q      <= wr_merged[iso_rate_pkg::CTRL_AVG +: 4];
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            host_rate_q <= iso_rate_pkg::HOST_RATE_RST;
            corr_q      <= 8'h0;
            sync_per_q  <= iso_rate_pkg::SYNC_PER_RST;
            sync_num_q  <= iso_rate_pkg::SYNC_NUM_RST;
        end else if (wr_ev) begin
            if (address_i == iso_rate_pkg::OFF_HOST_RATE) begin
                host_rate_q <= wr_merged;
            end
            if (address_i == iso_rate_pkg::OFF_CORR) begin
                corr_q <= wr_merged[7:0];
            end
            if (address_i == iso_rate_pkg::OFF_SYNC_PER && !enable_q) begin
                sync_per_q <= wr_merged[15:0];
            end
            if (address_i == iso_rate_pkg::OFF_SYNC_NUM && !enable_q) begin
                sync_num_q <= wr_merged[11:0];
            end
        end
    end

    // ****************************************
    // asynchronous sink feedback
    // ****************************************
    assign fb_run  = enable_q && (mode_q == iso_rate_pkg::MODE_ASYNC);
    assign fb_tick = implicit_q ? tx_sample_i : mck_tick;

    rate_meter #(
        .CW (CW),
        .EW (EW)
    ) u_fb_meter (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .run_i    (fb_run),
        .tick_i   (fb_tick),
        .frame_i  (sof_tick),
        .exp_i    (fb_exp),
        .value_o  (fb_cnt),
        .valid_o  (fb_vld)
    );

    // drift correction is a signed offset in the lowest implemented bit
    assign adj = fb_cnt + {{(CW-8){corr_q[7]}}, corr_q};

    // only 10.10 or 12.13 bits are kept, padding reads zero
    assign fb_enc = hs_q ? {4'h0, adj[24:0], {iso_rate_pkg::HS_PAD{1'b0}}}
                         : {8'h0, adj[19:0], {iso_rate_pkg::FS_PAD{1'b0}}};

    // refresh one cycle after a correction write, once the new offset is in the sum
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fb_value_o <= 32'h0;
            fb_new_o   <= 1'b0;
            corr_upd_q <= 1'b0;
        end else begin
            fb_new_o   <= fb_vld;
            corr_upd_q <= wr_ev && address_i == iso_rate_pkg::OFF_CORR;
            if (fb_vld || corr_upd_q) begin
                fb_value_o <= fb_enc;
            end
        end
    end

    // ****************************************
    // adaptive sink rate
    // ****************************************
    assign sink_run = enable_q && (mode_q == iso_rate_pkg::MODE_ADAPT);

    rate_meter #(
        .CW (CW),
        .EW (EW)
    ) u_sink_meter (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .run_i    (sink_run),
        .tick_i   (rx_sample_i),
        .frame_i  (sof_tick),
        .exp_i    (avg_q),
        .value_o  (sink_cnt),
        .valid_o  (sink_vld)
    );

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sink_rate_o <= '0;
            chg_q       <= 1'b0;
        end else begin
            if (sink_vld) begin
                sink_rate_o <= sink_cnt;
            end
            // a change landing with the clear write still sets the flag
            if (sink_vld && sink_cnt != sink_rate_o) begin
                chg_q <= 1'b1;
            end else if (wr_ev && address_i == iso_rate_pkg::OFF_STATUS
                         && byteenable_i[0] && writedata_i[iso_rate_pkg::ST_CHG]) begin
                chg_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // adaptive source
    // ****************************************
    assign src_run = sink_run;
    // implicit: received average rescaled to 16.16, else host value per speed
    assign src_rate = implicit_q ? 32'(sink_rate_o << (iso_rate_pkg::FRAC_W - 32'(avg_q)))
                    : hs_q       ? host_rate_q
                                 : {host_rate_q[29:0], {iso_rate_pkg::FS_TO_Q16{1'b0}}};

    frac_accum #(
        .IW (16),
        .FW (iso_rate_pkg::FRAC_W)
    ) u_src_accum (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .run_i    (src_run),
        .frame_i  (sof_tick),
        .rate_i   (src_rate),
        .count_o  (src_samples_o),
        .strobe_o (src_samples_vld_o)
    );

    // ****************************************
    // synchronous sample clock
    // ****************************************
    // divider restarts on each frame tick and stops after the fixed count,
    // so a fast period can never push extra samples into a frame
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync_div_q  <= 16'h0;
            sync_cnt_q  <= 12'h0;
            sample_en_o <= 1'b0;
        end else begin
            sample_en_o <= 1'b0;
            if (!enable_q || mode_q != iso_rate_pkg::MODE_SYNC) begin
                sync_div_q <= 16'h0;
                sync_cnt_q <= 12'h0;
            end else if (sof_tick) begin
                sync_div_q <= 16'h0;
                sync_cnt_q <= 12'h0;
            end else if (sync_cnt_q < sync_num_q) begin
                if (sync_div_q >= sync_per_q - 16'h1) begin
                    sync_div_q  <= 16'h0;
                    sync_cnt_q  <= sync_cnt_q + 12'h1;
                    sample_en_o <= 1'b1;
                end else begin
                    sync_div_q <= sync_div_q + 16'h1;
                end
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_ctrl_frozen: assert property (@(posedge clk_i) disable iff (!resetn_i)
        enable_q && $past(enable_q) |-> $stable(p_q) && $stable(mode_q) && $stable(hs_q))
        else $error("rate setup changed while enabled");

    a_p_range: assert property (@(posedge clk_i) disable iff (!resetn_i)
        p_eff <= k && (fb_exp <= k))
        else $error("divider exponent out of range");

    a_fb_once: assert property (@(posedge clk_i) disable iff (!resetn_i)
        fb_new_o && !implicit_q && (fb_exp != 4'h0) |=> !fb_new_o)
        else $error("feedback announced twice in a period");

    a_fb_fs_pad: assert property (@(posedge clk_i) disable iff (!resetn_i)
        fb_new_o && !hs_q |-> fb_value_o[31:24] == 8'h0 && fb_value_o[3:0] == 4'h0)
        else $error("full speed feedback padding not zero");

    a_fb_hs_pad: assert property (@(posedge clk_i) disable iff (!resetn_i)
        fb_new_o && hs_q |-> fb_value_o[31:28] == 4'h0 && fb_value_o[2:0] == 3'h0)
        else $error("high speed feedback padding not zero");

    a_fb_latch: assert property (@(posedge clk_i) disable iff (!resetn_i)
        fb_vld |=> fb_new_o && fb_value_o == $past(fb_enc))
        else $error("feedback not latched after period end");

    a_sync_cap: assert property (@(posedge clk_i) disable iff (!resetn_i)
        sample_en_o |-> sync_cnt_q <= sync_num_q && sync_cnt_q != 12'h0)
        else $error("synchronous sample count exceeded");

    a_src_strobe: assert property (@(posedge clk_i) disable iff (!resetn_i)
        src_run && sof_tick |=> src_samples_vld_o)
        else $error("adaptive source missed a frame");

    a_sink_change: assert property (@(posedge clk_i) disable iff (!resetn_i)
        sink_vld && sink_cnt != sink_rate_o |=> chg_q && sink_rate_o == $past(sink_cnt))
        else $error("sink rate change not flagged");

    a_bus_wait: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (read_i || write_i) && waitrequest_o |=> !waitrequest_o ##1 waitrequest_o)
        else $error("bus answer timing broken");

    assign waitrequest_o = wait_q;
endmodule // iso_rate_feedback

// ---- iso_rate_pkg.sv ----
package iso_rate_pkg;
    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [5:0] OFF_CTRL      = 6'h00;
    localparam logic [5:0] OFF_STATUS    = 6'h04;
    localparam logic [5:0] OFF_FEEDBACK  = 6'h08;
    localparam logic [5:0] OFF_HOST_RATE = 6'h0c;
    localparam logic [5:0] OFF_CORR      = 6'h10;
    localparam logic [5:0] OFF_SYNC_PER  = 6'h14;
    localparam logic [5:0] OFF_SYNC_NUM  = 6'h18;
    localparam logic [5:0] OFF_SINK_RATE = 6'h1c;
    localparam logic [5:0] OFF_SRC_COUNT = 6'h20;

    // ****************************************
    // control and status fields
    // ****************************************
    localparam int CTRL_EN   = 0;
    localparam int CTRL_HS   = 1;
    localparam int CTRL_P_LO = 2;
    localparam int CTRL_MODE = 6;
    localparam int CTRL_IMPL = 8;
    localparam int CTRL_AVG  = 9;
    localparam int ST_PWARN  = 0;
    localparam int ST_FBVLD  = 1;
    localparam int ST_CHG    = 2;
    localparam int ST_CLAMP  = 3;

    // ****************************************
    // frame-count exponents and formats
    // ****************************************
    localparam logic [3:0] K_FS       = 4'ha;
    localparam logic [3:0] K_HS       = 4'hd;
    localparam int         FS_PAD     = 4;
    localparam int         HS_PAD     = 3;
    localparam int         FS_TO_Q16  = 2;
    localparam int         FRAC_W     = 16;
    localparam int         FRAME_US   = 1000;
    localparam int         CLK_MHZ    = 10;

    // ****************************************
    // values after reset
    // ****************************************
    localparam logic [3:0]  P_RST        = 4'h4;
    localparam logic [3:0]  AVG_RST      = 4'h4;
    localparam logic [31:0] HOST_RATE_RST = 32'h0;
    localparam logic [15:0] SYNC_PER_RST = 16'h00d0;
    localparam logic [11:0] SYNC_NUM_RST = 12'h030;

    typedef enum logic [1:0] {
        MODE_SYNC,
        MODE_ASYNC,
        MODE_ADAPT
    } mode_t;
endpackage

// ---- rate_meter.sv ----
`timescale 1ns/1ps
// counts pulses over 2**exp frames (2**14 for exp 15) and latches the total without losing any pulse
module rate_meter #(
    parameter int CW = 25,
    parameter int EW = 4
) (
    input  wire logic          clk_i,
    input  wire logic          resetn_i,
    input  wire logic          run_i,
    input  wire logic          tick_i,
    input  wire logic          frame_i,
    input  wire logic [EW-1:0] exp_i,
    output logic      [CW-1:0] value_o,
    output logic               valid_o
);
    logic [13:0]   fcnt_q;
    logic [CW-1:0] cnt_q;
    logic [13:0]   last;
    logic          period_end;

    if (EW > 4) begin : g_bad
        $error("rate_meter: exponent wider than the frame counter");
    end

    assign last       = (14'h1 << exp_i) - 14'h1;
    assign period_end = run_i && frame_i && (fcnt_q >= last);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fcnt_q <= 14'h0;
        end else if (!run_i || period_end) begin
            fcnt_q <= 14'h0;
        end else if (frame_i) begin
            fcnt_q <= fcnt_q + 14'h1;
        end
    end

    // the pulse of the closing cycle starts the next period so none is skipped
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q   <= '0;
            value_o <= '0;
            valid_o <= 1'b0;
        end else begin
            valid_o <= period_end;
            if (!run_i) begin
                cnt_q <= '0;
            end else if (period_end) begin
                value_o <= cnt_q;
                cnt_q   <= {{(CW-1){1'b0}}, tick_i};
            end else if (tick_i) begin
                cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // rate_meter

// ---- tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; $display("[ERR] t=%0t %h %h", $time, a, e); end end
module tb_top;
    logic        clk_i = 1'b0, resetn_i = 1'b0, read_i = 1'b0, write_i = 1'b0, rx_sample_i = 1'b0;
    logic [5:0]  address_i = 6'h00;
    logic [31:0] writedata_i = 32'h0, readdata_o, fb_value_o, rd;
    logic [3:0]  byteenable_i = 4'hf;
    logic        waitrequest_o, fb_new_o, src_samples_vld_o, sample_en_o, sof, mclk;
    logic [15:0] src_samples_o, acc;
    logic [24:0] sink_rate_o;
    int          err_total = 0, checks = 0, rxc = 0, k;
    typedef struct {logic w; logic [5:0] a; logic [31:0] d; logic [31:0] e;} row_t;
    // ****************************************
    // register rows: a write row is read back at once
    // ****************************************
    row_t rows[8] = '{'{0, 6'h00, 0, 32'h850}, '{0, 6'h14, 0, 32'hd0}, '{0, 6'h18, 0, 32'h30},
        '{0, 6'h0c, 0, 32'h0}, '{1, 6'h24, 32'hffffffff, 32'h0}, '{1, 6'h08, 32'h1234, 32'h0},
        '{1, 6'h14, 32'ha, 32'ha}, '{1, 6'h18, 32'h5, 32'h5}};
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    // one received sample every 8 cycles, 25 per 200-cycle frame
    always @(posedge clk_i) begin
        rxc <= (rxc == 7) ? 0 : rxc + 1;
        rx_sample_i <= (rxc == 0);
    end
    host_model #(.FRAME(200)) u_host (.clk_i(clk_i), .sof_o(sof), .mclk_o(mclk));
    iso_rate_feedback u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .address_i(address_i), .read_i(read_i),
        .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o), .sof_i(sof), .master_clk_i(mclk), .rx_sample_i(rx_sample_i),
        .tx_sample_i(rx_sample_i), .fb_value_o(fb_value_o), .fb_new_o(fb_new_o), .src_samples_o(src_samples_o),
        .src_samples_vld_o(src_samples_vld_o), .sample_en_o(sample_en_o), .sink_rate_o(sink_rate_o));
    task automatic tally_and_finish;
        if (err_total == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        address_i <= a;
        write_i <= w;
        read_i <= !w;
        writedata_i <= d;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (waitrequest_o === 1'b0) break;
        end
        rd = readdata_o;
        write_i <= 1'b0;
        read_i <= 1'b0;
        if (n == 50) begin
            err_total++;
            tally_and_finish();
        end
    endtask
    task automatic wait_hi(input logic src);
        int n;
        for (n = 0; n < 20000; n++) begin
            @(posedge clk_i);
            #1;
            if ((src ? src_samples_vld_o : fb_new_o) === 1'b1) break;
        end
        if (n == 20000) begin
            err_total++;
            tally_and_finish();
        end
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d);
            bus(1'b0, rows[i].a, 32'h0);
            `CHK(rd, rows[i].e)
        end
        // full speed async, 4-frame periods: 200 master edges
        bus(1'b1, 6'h00, 32'h61);
        wait_hi(1'b0);
        wait_hi(1'b0);
        `CHK(fb_value_o, 32'hc80)
        bus(1'b0, 6'h08, 32'h0);
        `CHK(rd, 32'hc80)
        bus(1'b1, 6'h00, 32'ha1);
        bus(1'b0, 6'h00, 32'h0);
        `CHK(rd, 32'h61)
        bus(1'b1, 6'h00, 32'h0);
        bus(1'b1, 6'h00, 32'h6f);
        wait_hi(1'b0);
        wait_hi(1'b0);
        `CHK(fb_value_o, 32'h640)
        bus(1'b1, 6'h00, 32'h0);
        // exponent 15 is clamped to 10: one-frame periods
        bus(1'b1, 6'h00, 32'h7d);
        wait_hi(1'b0);
        wait_hi(1'b0);
        `CHK(fb_value_o, 32'h320)
        bus(1'b0, 6'h04, 32'h0);
        `CHK({rd[3], rd[0]}, 2'b11)
        // a correction of minus two takes 50 master edges down to 48
        bus(1'b1, 6'h10, 32'hfe);
        bus(1'b0, 6'h08, 32'h0);
        `CHK(rd, 32'h300)
        bus(1'b1, 6'h00, 32'h0);
        // adaptive: 2.5 samples a frame gives 10 over four frames
        bus(1'b1, 6'h0c, 32'ha000);
        bus(1'b1, 6'h00, 32'h891);
        wait_hi(1'b1);
        acc = 16'h0;
        for (k = 0; k < 4; k++) begin
            wait_hi(1'b1);
            acc = acc + src_samples_o;
        end
        `CHK(acc, 16'ha)
        repeat (8000) @(posedge clk_i);
        `CHK(sink_rate_o, 25'd400)
        bus(1'b0, 6'h04, 32'h0);
        `CHK(rd[2], 1'b1)
        bus(1'b1, 6'h04, 32'h4);
        bus(1'b0, 6'h04, 32'h0);
        `CHK(rd[2], 1'b0)
        bus(1'b1, 6'h00, 32'h0);
        // implicit adaptive source: 400 over 16 frames gives 25 a frame
        bus(1'b1, 6'h00, 32'h991);
        wait_hi(1'b1);
        wait_hi(1'b1);
        `CHK(src_samples_o, 16'h19)
        bus(1'b1, 6'h00, 32'h0);
        // synchronous: 5 samples every frame, window spans four frames
        bus(1'b1, 6'h00, 32'h11);
        repeat (400) @(posedge clk_i);
        acc = 16'h0;
        repeat (800) begin
            @(posedge clk_i);
            #1;
            if (sample_en_o === 1'b1) acc = acc + 16'h1;
        end
        `CHK(acc, 16'h14)
        // reset in mid-run returns the control register to its value after reset
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        `CHK({waitrequest_o, sample_en_o, fb_value_o}, {1'b1, 1'b0, 32'h0})
        resetn_i <= 1'b1;
        bus(1'b0, 6'h00, 32'h0);
        `CHK(rd, 32'h850)
        tally_and_finish();
    end
endmodule // tb_top
